/* rtl/nsf_map.svh */
// offsets, field positions, reset values and timing counts for the unit
// assumes inclusion by bare name from the design files
`ifndef NSF_MAP_SVH
`define NSF_MAP_SVH
`define NSF_REG_CTRL     4'h0
`define NSF_REG_STATUS   4'h4
`define NSF_REG_FAULTS   4'h8
`define NSF_REG_DROPS    4'hC
`define NSF_CTRL_EVICT   0
`define NSF_CTRL_RESET   32'h0000_0000
`define NSF_VEC_BYTES    16
`define NSF_LINE_BYTES   64
`define NSF_LINE_CHUNKS  4
`define NSF_DRAIN_NS     64
`define NSF_DRAIN_CYC    ((`NSF_DRAIN_NS + 7) / 8)
`endif

/* rtl/nsf_pkg.sv */
// types shared by the unit's files
// assumes nsf_map.svh on the include path
package nsf_pkg;
  typedef enum logic [2:0] {
    NSF_OP_NONE   = 3'h0,
    NSF_OP_STREAM = 3'h1,
    NSF_OP_PS     = 3'h2,
    NSF_OP_MASKED = 3'h3,
    NSF_OP_LOAD   = 3'h4,
    NSF_OP_SFENCE = 3'h5,
    NSF_OP_LOAD_FENCE = 3'h6
  } nsf_op_e;
  typedef enum logic [1:0] {
    NSF_MT_UC = 2'h0,
    NSF_MT_WC = 2'h1,
    NSF_MT_WB = 2'h2,
    NSF_MT_WT = 2'h3
  } nsf_mtype_e;
  typedef enum logic [1:0] {
    NSF_ST_IDLE  = 2'h0,
    NSF_ST_FENCE = 2'h1,
    NSF_ST_LOAD  = 2'h2
  } nsf_state_e;
endpackage

/* rtl/nsf_wc_buffer.sv */
// one write-combining line buffer with per-byte valid bits
// assumes a single clock; flush handshake with the memory side
`include "nsf_map.svh"
module nsf_wc_buffer
  import nsf_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wr_i,
  input  wire logic [31:0]  addr_i,
  input  wire logic [127:0] data_i,
  input  wire logic [15:0]  be_i,
  input  wire logic         flush_i,
  input  wire logic         mem_ack_i,
  output logic              busy_o,
  output logic              hit_o,
  output logic              mem_req_o,
  output logic [31:0]       mem_addr_o,
  output logic [511:0]      mem_data_o,
  output logic [63:0]       mem_be_o
);
  logic [25:0]  tag;
  logic [511:0] line;
  logic [63:0]  bv;
  logic         pend;
  logic [25:0]  next_tag;
  logic [511:0] next_line;
  logic [63:0]  next_bv;
  logic         next_pend;
  logic [1:0]   slot;

  assign slot   = addr_i[5:4];
  assign hit_o  = (|bv) && (tag == addr_i[31:6]);
  // a flush about to start counts as busy, so no foreign line merges in
  assign busy_o = pend || (flush_i && (|bv));

  always_comb begin
    next_tag  = tag;
    next_line = line;
    next_bv   = bv;
    next_pend = pend;
    if (pend && mem_ack_i) begin
      next_pend = 1'b0;
      next_bv   = 64'h0;
    end else if (!pend && flush_i && (|bv)) begin
      next_pend = 1'b1;
    end
    if (wr_i && !pend) begin
      // later writes overwrite the same bytes: only the last survives
      if (!(|bv)) next_tag = addr_i[31:6];
      for (int b = 0; b < `NSF_VEC_BYTES; b++) begin
        if (be_i[b]) begin
          next_line[{slot, 4'h0} * 8 + b * 8 +: 8] = data_i[b*8 +: 8];
          next_bv[{slot, 4'h0} + b] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tag  <= 26'h0;
      line <= 512'h0;
      bv   <= 64'h0;
      pend <= 1'b0;
    end else begin
      tag  <= next_tag;
      line <= next_line;
      bv   <= next_bv;
      pend <= next_pend;
    end
  end

  assign mem_req_o  = pend;
  assign mem_addr_o = {tag, 6'h0};
  assign mem_data_o = line;
  assign mem_be_o   = bv;
endmodule

/* rtl/nsf_unit.sv */
// streaming store, streaming load and fence ordering unit
// assumes one core request at a time and a line-wide memory port
// Operation
// - aligned packed single store writes sixteen bytes as one unit
// - misaligned packed single store raises protection fault, no write
// - masked store writes a byte only when its mask top bit is set
// - masked store address comes from the destination index register
// - streaming stores may reach memory out of program order
// - streaming store misses never allocate a cache line
// - streaming load returns sixteen bytes; hint only for write-combining
// - write-combining load may fetch a whole line into a private buffer
// - later loads to unread buffered parts are served from that buffer
// - store fence: earlier stores visible before later stores
// - load fence: earlier loads complete before later loads
// - coherent streaming store acts as write-combining store
// - rereading a streamed location returns its single latest value
// - non write-combining cached hit may stay in cache past a fence
// - write-combining reads never fill the caches
// - evict-only policy flushes cached copy whatever the memory type
// - same-line stores merge; repeated bytes keep only final value
// - first-level hit merges in place; second-level hit flushes to memory
//
// Implementation choices: the register offsets and the Wishbone register port.
`include "nsf_map.svh"
module nsf_unit
  import nsf_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // core side
  input  wire logic         req_valid_i,
  output logic              req_ready_o,
  input  wire logic [2:0]   req_op_i,
  input  wire logic [31:0]  req_addr_i,
  input  wire logic [31:0]  dest_index_i,
  input  wire logic [127:0] req_data_i,
  input  wire logic [127:0] req_mask_i,
  input  wire logic [1:0]   req_mtype_i,
  output logic              rsp_valid_o,
  output logic [127:0]      rsp_data_o,
  output logic              rsp_fault_o,
  // cache probe results for the request address
  input  wire logic         l1_hit_i,
  input  wire logic         l2_hit_i,
  output logic              l1_merge_o,
  output logic [127:0]      l1_merge_data_o,
  output logic [15:0]       l1_merge_be_o,
  output logic              l2_flush_o,
  output logic              fill_inhibit_o,
  // memory side, line wide
  output logic              mem_wr_req_o,
  output logic [31:0]       mem_wr_addr_o,
  output logic [511:0]      mem_wr_data_o,
  output logic [63:0]       mem_wr_be_o,
  input  wire logic         mem_wr_ack_i,
  output logic              mem_rd_req_o,
  output logic [31:0]       mem_rd_addr_o,
  input  wire logic         mem_rd_ack_i,
  input  wire logic [511:0] mem_rd_data_i,
  // wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [3:0]   wb_adr_i,
  input  wire logic [31:0]  wb_dat_i,
  input  wire logic [3:0]   wb_sel_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o
);
  nsf_state_e   state;
  nsf_state_e   next_state;
  logic [31:0]  ctrl;
  logic [31:0]  next_ctrl;
  logic [31:0]  faults;
  logic [31:0]  next_faults;
  logic [31:0]  drops;
  logic [31:0]  next_drops;
  logic         ack;
  logic         next_ack;
  logic [31:0]  rdat;
  logic [31:0]  next_rdat;
  logic [511:0] lbuf;
  logic [511:0] next_lbuf;
  logic [25:0]  ltag;
  logic [25:0]  next_ltag;
  logic [3:0]   lunread;
  logic [3:0]   next_lunread;
  logic         rvalid;
  logic         next_rvalid;
  logic [127:0] rdata;
  logic [127:0] next_rdata;
  logic         rfault;
  logic         next_rfault;
  logic [3:0]   dcnt;
  logic [3:0]   next_dcnt;
  logic [31:0]  ld_addr;
  logic [31:0]  next_ld_addr;

  logic         is_store;
  logic [31:0]  st_addr;
  logic [15:0]  st_be;
  logic         st_fault;
  logic         evict;
  logic         wcb_wr;
  logic         wcb_busy;
  logic         wcb_hit;
  logic         wcb_flush;
  logic         wb_req;

  function automatic logic [15:0] mask_to_be(input logic [127:0] m);
    for (int b = 0; b < `NSF_VEC_BYTES; b++) mask_to_be[b] = m[b*8+7];
  endfunction

  function automatic logic is_wc(input logic [1:0] mt);
    is_wc = (mt == NSF_MT_WC);
  endfunction

  assign evict    = ctrl[`NSF_CTRL_EVICT];
  assign is_store = (req_op_i == NSF_OP_STREAM) ||
                    (req_op_i == NSF_OP_PS) ||
                    (req_op_i == NSF_OP_MASKED);
  // masked form takes its address from the destination index register
  assign st_addr  = (req_op_i == NSF_OP_MASKED) ? dest_index_i
                                                 : req_addr_i;
  assign st_be    = (req_op_i == NSF_OP_MASKED) ?
                    mask_to_be(req_mask_i) : 16'hFFFF;
  assign st_fault = (req_op_i == NSF_OP_PS) &&
                    (req_addr_i[3:0] != 4'h0);

  // a new line may only enter once the old one is drained
  assign req_ready_o = (state == NSF_ST_IDLE) &&
                       !((is_store || (req_op_i == NSF_OP_LOAD)) &&
                         wcb_busy);

  // in-place merge only for non write-combining first-level hits
  // and never under the evict-only policy
  assign l1_merge_o = req_valid_i && req_ready_o && is_store &&
                      !st_fault && l1_hit_i && !evict &&
                      !is_wc(req_mtype_i);
  assign l1_merge_data_o = req_data_i;
  assign l1_merge_be_o   = st_be;
  // second-level hits, or any first-level hit not merged in place, push the line out
  assign l2_flush_o = req_valid_i && req_ready_o && is_store &&
                      !st_fault && !l1_merge_o &&
                      (l2_hit_i || l1_hit_i);
  // misses go around the caches; write-combining reads never fill
  assign fill_inhibit_o = (req_valid_i && is_store) ||
                          (state == NSF_ST_LOAD) ||
                          (req_valid_i && is_wc(req_mtype_i));
  assign wcb_wr = req_valid_i && req_ready_o && is_store &&
                  !st_fault && !l1_merge_o;
  // a store to another line forces the old line out first; a load of
  // a line still combining waits until it has reached memory
  assign wcb_flush = (state == NSF_ST_FENCE) ||
                     (req_valid_i && is_store && !wcb_hit) ||
                     (req_valid_i && (req_op_i == NSF_OP_LOAD) &&
                      wcb_hit);
  assign mem_rd_req_o  = (state == NSF_ST_LOAD);
  assign mem_rd_addr_o = {ld_addr[31:6], 6'h0};

  nsf_wc_buffer u_wcb (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_i       (wcb_wr),
    .addr_i     (st_addr),
    .data_i     (req_data_i),
    .be_i       (st_be),
    .flush_i    (wcb_flush),
    .mem_ack_i  (mem_wr_ack_i),
    .busy_o     (wcb_busy),
    .hit_o      (wcb_hit),
    .mem_req_o  (mem_wr_req_o),
    .mem_addr_o (mem_wr_addr_o),
    .mem_data_o (mem_wr_data_o),
    .mem_be_o   (mem_wr_be_o)
  );

  function automatic logic wcb_hit_any();
    wcb_hit_any = mem_wr_req_o;
  endfunction

  always_comb begin
    next_state   = state;
    next_lbuf    = lbuf;
    next_ltag    = ltag;
    next_lunread = lunread;
    next_rvalid  = 1'b0;
    next_rdata   = rdata;
    next_rfault  = 1'b0;
    next_faults  = faults;
    next_dcnt    = dcnt;
    next_ld_addr = ld_addr;
    unique case (state)
      NSF_ST_IDLE: begin
        if (req_valid_i && req_ready_o) begin
          if (is_store) begin
            next_rvalid = 1'b1;
            next_rfault = st_fault;
            if (st_fault) next_faults = faults + 32'h1;
          end else if (req_op_i == NSF_OP_LOAD) begin
            if (is_wc(req_mtype_i) && (ltag == req_addr_i[31:6]) &&
                lunread[req_addr_i[5:4]]) begin
              next_rvalid = 1'b1;
              next_rdata  = lbuf[{req_addr_i[5:4], 7'h0} +: 128];
              next_lunread[req_addr_i[5:4]] = 1'b0;
            end else begin
              next_ld_addr = req_addr_i;
              next_state   = NSF_ST_LOAD;
            end
          end else if (req_op_i == NSF_OP_SFENCE) begin
            next_dcnt  = 4'(`NSF_DRAIN_CYC);
            next_state = NSF_ST_FENCE;
          end else if (req_op_i == NSF_OP_LOAD_FENCE) begin
            // loads are blocking here, so earlier ones are done
            next_rvalid = 1'b1;
          end else begin
            next_rvalid = 1'b1;
          end
        end
      end
      NSF_ST_FENCE: begin
        // held until the drain count has run out and the combining line has reached memory
        if (dcnt != 4'h0) next_dcnt = dcnt - 4'h1;
        if (!wcb_busy && !wcb_hit_any() && dcnt == 4'h0) begin
          next_rvalid = 1'b1;
          next_state  = NSF_ST_IDLE;
        end
      end
      NSF_ST_LOAD: begin
        if (mem_rd_ack_i) begin
          next_rvalid = 1'b1;
          next_rdata  = mem_rd_data_i[{ld_addr[5:4], 7'h0} +: 128];
          next_state  = NSF_ST_IDLE;
          if (is_wc(req_mtype_i)) begin
            next_lbuf    = mem_rd_data_i;
            next_ltag    = ld_addr[31:6];
            next_lunread = 4'hF;
            next_lunread[ld_addr[5:4]] = 1'b0;
          end else begin
            next_lunread = 4'h0;
          end
        end
      end
      default: next_state = NSF_ST_IDLE;
    endcase
    // a store to a buffered line makes the stale copy unusable
    if (wcb_wr && (st_addr[31:6] == ltag)) next_lunread = 4'h0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state   <= NSF_ST_IDLE;
      lbuf    <= 512'h0;
      ltag    <= 26'h0;
      lunread <= 4'h0;
      rvalid  <= 1'b0;
      rdata   <= 128'h0;
      rfault  <= 1'b0;
      faults  <= 32'h0;
      dcnt    <= 4'h0;
      ld_addr <= 32'h0;
    end else begin
      state   <= next_state;
      lbuf    <= next_lbuf;
      ltag    <= next_ltag;
      lunread <= next_lunread;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rfault  <= next_rfault;
      faults  <= next_faults;
      dcnt    <= next_dcnt;
      ld_addr <= next_ld_addr;
    end
  end

  assign rsp_valid_o = rvalid;
  assign rsp_data_o  = rdata;
  assign rsp_fault_o = rfault;

  // register slave: one-cycle ack, unmapped reads return zero
  assign wb_req = wb_cyc_i && wb_stb_i && !ack;

  always_comb begin
    next_ack   = wb_req;
    next_ctrl  = ctrl;
    next_drops = drops;
    next_rdat  = rdat;
    if (wb_req) begin
      next_rdat = 32'h0;
      unique case (wb_adr_i)
        `NSF_REG_CTRL: begin
          if (wb_we_i && wb_sel_i[0]) next_ctrl = {31'h0, wb_dat_i[0]};
          next_rdat = ctrl;
        end
        `NSF_REG_STATUS:
          next_rdat = {24'h0, lunread, wcb_busy, wcb_hit_any(),
                       state};
        `NSF_REG_FAULTS: next_rdat = faults;
        `NSF_REG_DROPS: begin
          if (wb_we_i) next_drops = 32'h0;
          next_rdat = drops;
        end
        default: next_rdat = 32'h0;
      endcase
    end
    if (l2_flush_o) next_drops = next_drops + 32'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;
      ctrl  <= `NSF_CTRL_RESET;
      drops <= 32'h0;
      rdat  <= 32'h0;
    end else begin
      ack   <= next_ack;
      ctrl  <= next_ctrl;
      drops <= next_drops;
      rdat  <= next_rdat;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;
endmodule

/* verif/nsf_unit_props.sv */
// assertions on the ports of the streaming store and fence unit
// assumes a bind onto nsf_unit, one clock and a sync reset
module nsf_unit_props
  import nsf_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        req_valid_i,
  input wire logic        req_ready_o,
  input wire logic [2:0]  req_op_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [1:0]  req_mtype_i,
  input wire logic        rsp_valid_o,
  input wire logic        rsp_fault_o,
  input wire logic        fill_inhibit_o,
  input wire logic        mem_wr_req_o,
  input wire logic        mem_wr_ack_i,
  input wire logic        mem_rd_req_o,
  input wire logic [31:0] mem_rd_addr_o,
  input wire logic        mem_rd_ack_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic ps_take;
  logic fence_wait;
  logic next_fence_wait;
  assign take = req_valid_i && req_ready_o;
  assign ps_take = take && req_op_i == NSF_OP_PS;
  // fence kept open until answered, so its drain can be judged
  always_comb begin
    next_fence_wait = fence_wait;
    if (take && req_op_i == NSF_OP_SFENCE) begin
      next_fence_wait = 1'b1;
    end else if (rsp_valid_o) begin
      next_fence_wait = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    fence_wait <= rst_i ? 1'b0 : next_fence_wait;
  end
  a_ps_aligned_ok: assert property (ps_take && req_addr_i[3:0] == 4'h0
    |=> rsp_valid_o && !rsp_fault_o) else $error("aligned store faulted");
  a_ps_misalign_fault: assert property (ps_take && req_addr_i[3:0] != 4'h0
    |=> rsp_valid_o && rsp_fault_o) else $error("misaligned store no fault");
  a_fault_with_rsp: assert property (rsp_fault_o |-> rsp_valid_o)
    else $error("fault without response");
  a_fence_drained: assert property (fence_wait && rsp_valid_o
    |-> !mem_wr_req_o) else $error("fence answered with write pending");
  a_rd_line_align: assert property (mem_rd_req_o
    |-> mem_rd_addr_o[5:0] == 6'h00) else $error("line read not aligned");
  a_wc_no_fill: assert property (mem_rd_req_o && req_mtype_i == NSF_MT_WC
    |-> fill_inhibit_o) else $error("combining read may fill cache");
  a_load_answer: assert property (mem_rd_ack_i |=> rsp_valid_o)
    else $error("load not answered after read data");
  a_wr_req_hold: assert property (mem_wr_req_o && !mem_wr_ack_i
    |=> mem_wr_req_o) else $error("line write dropped before ack");
  a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("bus cycle not acknowledged");
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  c_fault: cover property (rsp_valid_o && rsp_fault_o);
  c_line_read: cover property (mem_rd_ack_i);
  c_fence_wait: cover property (fence_wait && mem_wr_req_o);
endmodule

bind nsf_unit nsf_unit_props nsf_unit_props_i (.clk_i, .rst_i, .req_valid_i,
  .req_ready_o, .req_op_i, .req_addr_i, .req_mtype_i, .rsp_valid_o,
  .rsp_fault_o, .fill_inhibit_o, .mem_wr_req_o, .mem_wr_ack_i, .mem_rd_req_o,
  .mem_rd_addr_o, .mem_rd_ack_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

/* verif/nsf_mem_model.sv */
// line-wide system memory behind the unit, with adjustable answer delay
// assumes line-aligned requests held until acknowledged
module nsf_mem_model (
  input  wire logic         clk_i,
  input  wire logic [2:0]   delay_i,
  input  wire logic         wr_req_i,
  input  wire logic [31:0]  wr_addr_i,
  input  wire logic [511:0] wr_data_i,
  input  wire logic [63:0]  wr_be_i,
  output logic              wr_ack_o,
  input  wire logic         rd_req_i,
  input  wire logic [31:0]  rd_addr_i,
  output logic              rd_ack_o,
  output logic [511:0]      rd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  function automatic logic [7:0] rd_byte(int a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5A;
  endfunction
  initial begin
    wr_ack_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (wr_req_i && !wr_ack_o) begin
        repeat (delay_i) @(posedge clk_i);
        for (int i = 0; i < 64; i++) begin
          if (wr_be_i[i]) mem[{wr_addr_i[31:6], 6'h00} + i] = wr_data_i[8*i +: 8];
        end
        wr_ack_o <= 1'b1;
      end else begin
        wr_ack_o <= 1'b0;
      end
    end
  end
  // released data bus toggles, so stale data is never mistaken for valid
  initial begin
    rd_ack_o = 1'b0;
    rd_data_o = '0;
    forever begin
      @(posedge clk_i);
      if (rd_req_i && !rd_ack_o) begin
        repeat (delay_i) @(posedge clk_i);
        for (int i = 0; i < 64; i++) begin
          rd_data_o[8*i +: 8] <= rd_byte({rd_addr_i[31:6], 6'h00} + i);
        end
        rd_ack_o <= 1'b1;
      end else begin
        rd_ack_o <= 1'b0;
        rd_data_o <= ~rd_data_o;
      end
    end
  end
endmodule

/* verif/nsf_unit_tb.sv */
// self-checking bench for the streaming store and fence unit
// assumes the unit, its checker and the memory model are compiled first
module nsf_unit_tb
  import nsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         req_valid_i, req_ready_o, rsp_valid_o, rsp_fault_o;
  logic         l1_hit_i, l2_hit_i, l1_merge_o, l2_flush_o, fill_inhibit_o;
  logic         mem_wr_req_o, mem_wr_ack_i, mem_rd_req_o, mem_rd_ack_i;
  logic         wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, last_fault, saw_l1;
  logic         saw_l2;
  logic [1:0]   req_mtype_i, mt;
  logic [2:0]   req_op_i, delay, op;
  logic [3:0]   wb_adr_i, wb_sel_i;
  logic [15:0]  l1_merge_be_o, mbe;
  logic [31:0]  req_addr_i, dest_index_i, mem_wr_addr_o, mem_rd_addr_o;
  logic [31:0]  wb_dat_i, wb_dat_o, q, a;
  logic [63:0]  mem_wr_be_o;
  logic [127:0] req_data_i, req_mask_i, rsp_data_o, l1_merge_data_o;
  logic [127:0] last_data, d, m, e;
  logic [511:0] mem_wr_data_o, mem_rd_data_i;
  logic [7:0]   exp_mem [int];
  int           err_total = 0;
  int           cmp_count = 0;
  nsf_unit nsf_unit_i (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_op_i,
    .req_addr_i, .dest_index_i, .req_data_i, .req_mask_i, .req_mtype_i,
    .rsp_valid_o, .rsp_data_o, .rsp_fault_o, .l1_hit_i, .l2_hit_i, .l1_merge_o,
    .l1_merge_data_o, .l1_merge_be_o, .l2_flush_o, .fill_inhibit_o,
    .mem_wr_req_o, .mem_wr_addr_o, .mem_wr_data_o, .mem_wr_be_o, .mem_wr_ack_i,
    .mem_rd_req_o, .mem_rd_addr_o, .mem_rd_ack_i, .mem_rd_data_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o);
  nsf_mem_model nsf_mem_model_i (.clk_i, .delay_i(delay),
    .wr_req_i(mem_wr_req_o), .wr_addr_i(mem_wr_addr_o),
    .wr_data_i(mem_wr_data_o), .wr_be_i(mem_wr_be_o), .wr_ack_o(mem_wr_ack_i),
    .rd_req_i(mem_rd_req_o), .rd_addr_i(mem_rd_addr_o),
    .rd_ack_o(mem_rd_ack_i), .rd_data_o(mem_rd_data_i));
  always #4 clk_i = ~clk_i;

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [127:0] exp, logic [127:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] model_byte(int b);
    return exp_mem.exists(b) ? exp_mem[b] : b[7:0] ^ 8'h5A;
  endfunction
  task automatic wb_io(logic we, logic [3:0] adr, logic [31:0] wd);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    check("bus ack", 1, wb_ack_o);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // masked stores get a wrong explicit address, so the index source shows
  task automatic core(logic [2:0] o, logic [31:0] ad, logic [127:0] dd, mm,
                      logic [1:0] t, logic h1, h2);
    int n;
    req_valid_i <= 1'b1;
    req_op_i <= o;
    req_addr_i <= (o == NSF_OP_MASKED) ? ~ad : ad;
    dest_index_i <= (o == NSF_OP_MASKED) ? ad : ~ad;
    req_data_i <= dd;
    req_mask_i <= mm;
    req_mtype_i <= t;
    l1_hit_i <= h1;
    l2_hit_i <= h2;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 200);
    // probe answers stand only in the cycle the request is taken
    saw_l1 = l1_merge_o === 1'b1;
    saw_l2 = l2_flush_o === 1'b1;
    mbe = l1_merge_be_o;
    req_valid_i <= 1'b0;
    do begin @(posedge clk_i); n++; end while (rsp_valid_o !== 1'b1 && n < 400);
    check("response", 1, rsp_valid_o);
    last_fault = rsp_fault_o;
    last_data = rsp_data_o;
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    summarize();
  end
  initial begin
    void'($urandom(70922));
    {req_valid_i, l1_hit_i, l2_hit_i, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {req_op_i, req_mtype_i, req_addr_i, dest_index_i, delay} = '0;
    {req_data_i, req_mask_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_io(1'b0, 4'h0, 32'h0);
    check("ctrl reset", 32'h0, q);
    wb_io(1'b0, 4'h2, 32'h0);
    check("unmapped read", 32'h0, q);
    for (int k = 0; k < 24; k++) begin
      op = 3'h1 + 3'($urandom_range(2));
      a = 32'h1000 + 32'(16 * $urandom_range(15));
      d = {$urandom, $urandom, $urandom, $urandom};
      m = {$urandom, $urandom, $urandom, $urandom};
      mt = $urandom_range(1) ? NSF_MT_WC : NSF_MT_WB;
      delay <= 3'($urandom_range(4));
      core(op, a, d, m, mt, 1'b0, 1'b0);
      check("store fault", 0, last_fault);
      for (int i = 0; i < 16; i++) begin
        if (op != NSF_OP_MASKED || m[8*i+7]) exp_mem[a+i] = d[8*i +: 8];
      end
    end
    core(NSF_OP_PS, 32'h1004, '1, '1, NSF_MT_WC, 1'b0, 1'b0);
    check("misaligned fault", 1, last_fault);
    core(NSF_OP_SFENCE, 32'h0, '0, '0, NSF_MT_WC, 1'b0, 1'b0);
    for (int j = 32'h1000; j < 32'h1100; j++) begin
      check("memory byte", model_byte(j), nsf_mem_model_i.rd_byte(j));
    end
    for (int c = 0; c < 8; c++) begin
      a = 32'h1000 + 32'(16 * c);
      for (int i = 0; i < 16; i++) e[8*i +: 8] = model_byte(a + i);
      core(NSF_OP_LOAD, a, '0, '0, c < 4 ? NSF_MT_WC : NSF_MT_WB, 1'b0, 1'b0);
      check("load data", e, last_data);
    end
    core(NSF_OP_LOAD_FENCE, 32'h0, '0, '0, NSF_MT_WC, 1'b0, 1'b0);
    m = {$urandom, $urandom, $urandom, $urandom};
    core(NSF_OP_MASKED, 32'h2000, d, m, NSF_MT_WB, 1'b1, 1'b0);
    check("l1 merge", 1, saw_l1);
    check("l1 merge flush", 0, saw_l2);
    for (int i = 0; i < 16; i++) e[i] = m[8*i+7];
    check("merge enables", e[15:0], mbe);
    core(NSF_OP_STREAM, 32'h2040, '1, '1, NSF_MT_WB, 1'b0, 1'b1);
    check("l2 flush", 1, saw_l2);
    core(NSF_OP_STREAM, 32'h20C0, '1, '1, NSF_MT_WC, 1'b1, 1'b0);
    check("wc hit merge", 0, saw_l1);
    wb_io(1'b1, 4'h0, 32'h1);
    core(NSF_OP_STREAM, 32'h2080, '1, '1, NSF_MT_WB, 1'b1, 1'b0);
    check("evict merge", 0, saw_l1);
    check("evict flush", 1, saw_l2);
    core(NSF_OP_SFENCE, 32'h0, '0, '0, NSF_MT_WC, 1'b0, 1'b0);
    check("evicted line", 8'hFF, nsf_mem_model_i.rd_byte(32'h2080));
    check("wc line", 8'hFF, nsf_mem_model_i.rd_byte(32'h20C0));
    wb_io(1'b0, 4'h8, 32'h0);
    check("fault count", 32'h1, q);
    wb_io(1'b0, 4'hC, 32'h0);
    check("flush count", 32'h3, q);
    wb_io(1'b1, 4'hC, 32'h0);
    wb_io(1'b0, 4'hC, 32'h0);
    check("flush clear", 32'h0, q);
    summarize();
  end
endmodule
